// >>> rtl/bcast_fanout.sv
// broadcast trigger fan-out of the step sequencer
// assumes step command strobe and sequencer controls come from logic on clk
// assumes one-cycle register strobes, read data taken the cycle after
// assumes compare units sample the pulses on the same clk
//
// The strobed register port and the register addresses were chosen for this implementation.
`include "bcast_defines.svh"

module bcast_fanout
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// register port
	input  wire bcast_pkg::bus_req_t bus,
	output logic [15:0]            rdata,
	// sequencer state
	input  wire logic              sequencer_enable,
	input  wire logic              sequencer_start,
	// step command execution
	input  wire logic              step_exec,
	input  wire logic              step_is_ctrl,
	input  wire logic [3:0]        step_option,
	// compare unit pulses
	output bcast_pkg::pulses_t     pulses
);

	// ---------------------------------------------------------------
	// register
	// ---------------------------------------------------------------
	logic [15:0] bte_r;
	logic        locked;
	logic        bcast;
	logic        wr_hit;
	logic        rd_hit;
	logic [4:0]  pulse_nxt;
	logic        clk1_r;
	wire [3:0]   trig_w;

	// register lock and bus decode
	assign locked = sequencer_enable && sequencer_start;
	assign wr_hit = bus.wr && (bus.addr == `BTE_ADDR);
	assign rd_hit = bus.rd && (bus.addr == `BTE_ADDR);

	// broadcast is the control step command with the all-ones option
	assign bcast  = step_exec && step_is_ctrl && (step_option == `BCAST_OPTION);

	// software writes, blocked while running
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			bte_r <= `BTE_RESET;
		else if (wr_hit && !locked)
			bte_r <= bus.wdata & `BTE_USED_MASK;
	end

	// read data one cycle after strobe, zero elsewhere
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata <= 16'h0000;
		else if (rd_hit)
			rdata <= bte_r;
		else
			rdata <= 16'h0000;
	end

	// ---------------------------------------------------------------
	// pulse generation
	// ---------------------------------------------------------------
	// enabled register bits, only in a broadcast cycle
	// register sampled in the command cycle: a write there lands after the pulse
	always_comb
	begin
		pulse_nxt = 5'h00;
		if (bcast)
			pulse_nxt = bte_r[`BTE_OC1_CLK:`BTE_OC1_TRIG];
	end

	// clock pulse to compare unit 1
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			clk1_r <= 1'b0;
		else
			clk1_r <= pulse_nxt[`BTE_OC1_CLK];
	end

	// trigger pulses, one flop per compare unit
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_trig
			logic fire_r;

			// one-cycle trigger for this unit
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					fire_r <= 1'b0;
				else
					fire_r <= pulse_nxt[`BTE_OC1_TRIG + g];
			end

			assign trig_w[g] = fire_r;
		end
	endgenerate

	// all pulses leave straight from their flops, in one cycle
	// no flop shared between units, so no unit can lag another
	assign pulses = '{clk1: clk1_r, trig: trig_w};

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_clk1;
		@(posedge clk) disable iff (!rstn)
		bcast |=> pulses.clk1 == $past(bte_r[`BTE_OC1_CLK]);
	endproperty
	a_clk1: assert property (p_clk1) else $error("clock pulse mismatch");

	property p_trig4;
		@(posedge clk) disable iff (!rstn)
		bcast |=> pulses.trig[3] == $past(bte_r[3]);
	endproperty
	a_trig4: assert property (p_trig4) else $error("unit 4 trigger mismatch");

	property p_trig3;
		@(posedge clk) disable iff (!rstn)
		bcast |=> pulses.trig[2] == $past(bte_r[2]);
	endproperty
	a_trig3: assert property (p_trig3) else $error("unit 3 trigger mismatch");

	property p_trig2;
		@(posedge clk) disable iff (!rstn)
		bcast |=> pulses.trig[1] == $past(bte_r[1]);
	endproperty
	a_trig2: assert property (p_trig2) else $error("unit 2 trigger mismatch");

	property p_trig1;
		@(posedge clk) disable iff (!rstn)
		bcast |=> pulses.trig[0] == $past(bte_r[0]);
	endproperty
	a_trig1: assert property (p_trig1) else $error("unit 1 trigger mismatch");

	property p_lock;
		@(posedge clk) disable iff (!rstn)
		locked |=> $stable(bte_r);
	endproperty
	a_lock: assert property (p_lock) else $error("register changed while locked");

	property p_only_bcast;
		@(posedge clk) disable iff (!rstn)
		!bcast |=> (pulses == '0);
	endproperty
	a_only_bcast: assert property (p_only_bcast) else $error("pulse without broadcast command");

	property p_width;
		@(posedge clk) disable iff (!rstn)
		(pulses != '0) && !$past(bcast, 2) |=> pulses == '0 || $past(bcast);
	endproperty
	a_width: assert property (p_width) else $error("pulse wider than one cycle");

	// register port and lock
	property p_wr_take;
		@(posedge clk) disable iff (!rstn)
		wr_hit && !locked |=> bte_r[4:0] == $past(bus.wdata[4:0]);
	endproperty
	a_wr_take: assert property (p_wr_take) else $error("unlocked write lost");

	property p_wr_locked;
		@(posedge clk) disable iff (!rstn)
		wr_hit && locked |=> bte_r == $past(bte_r);
	endproperty
	a_wr_locked: assert property (p_wr_locked) else $error("locked write took effect");

	property p_rd_data;
		@(posedge clk) disable iff (!rstn)
		rd_hit |=> rdata == $past(bte_r);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data differs from register");

	property p_rd_idle;
		@(posedge clk) disable iff (!rstn)
		!rd_hit |=> rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

	// pulse shape and command decode
	property p_clk1_off;
		@(posedge clk) disable iff (!rstn)
		bcast && !bte_r[`BTE_OC1_CLK] |=> !pulses.clk1;
	endproperty
	a_clk1_off: assert property (p_clk1_off) else $error("clock pulse while disabled");

	property p_trig_off;
		@(posedge clk) disable iff (!rstn)
		bcast |=> (pulses.trig & ~$past(bte_r[`BTE_OC4_TRIG:`BTE_OC1_TRIG])) == 4'h0;
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger while disabled");

	property p_same_cycle;
		@(posedge clk) disable iff (!rstn)
		bcast |=> pulses == $past(bte_r[`BTE_OC1_CLK:`BTE_OC1_TRIG]);
	endproperty
	a_same_cycle: assert property (p_same_cycle) else $error("enabled pulses not together");

	property p_one_wide;
		@(posedge clk) disable iff (!rstn)
		(pulses != 5'h00) && !bcast |=> pulses == 5'h00;
	endproperty
	a_one_wide: assert property (p_one_wide) else $error("pulse held past one cycle");

	property p_other_cmd;
		@(posedge clk) disable iff (!rstn)
		step_exec && !(step_is_ctrl && step_option == `BCAST_OPTION) |=> pulses == 5'h00;
	endproperty
	a_other_cmd: assert property (p_other_cmd) else $error("pulse from other step command");

	property p_idle_step;
		@(posedge clk) disable iff (!rstn)
		!step_exec |=> pulses == 5'h00;
	endproperty
	a_idle_step: assert property (p_idle_step) else $error("pulse without step command");

endmodule : bcast_fanout

// >>> inc/bcast_defines.svh
// constants for the broadcast trigger fan-out block
// assumes a plain strobe register port, one 16-bit register
//
// Behaviour
// - bit 4 set: one clock pulse to compare unit 1 per broadcast command
// - bit 3 set: trigger pulse to compare unit 4 per broadcast command
// - bit 2 set: trigger pulse to compare unit 3 per broadcast command
// - bit 1 set: trigger pulse to compare unit 2 per broadcast command
// - bit 0 set: trigger pulse to compare unit 1 per broadcast command
// - register ignores writes while sequencer enable and start are both 1
// - register consulted only by control step command with option 1111
`ifndef BCAST_DEFINES_SVH
`define BCAST_DEFINES_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define BTE_ADDR       4'h0
`define BTE_RESET      16'h0000
`define BTE_USED_MASK  16'h001F

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BTE_OC1_TRIG   0
`define BTE_OC4_TRIG   3
`define BTE_OC1_CLK    4

// ---------------------------------------------------------------
// step command coding
// ---------------------------------------------------------------
`define BCAST_OPTION   4'hF

`endif

// >>> inc/bcast_pkg.sv
// types for the broadcast trigger fan-out block
// assumes nothing beyond the defines header
package bcast_pkg;

	// pulses to the four compare units
	typedef struct packed {
		logic       clk1;
		logic [3:0] trig;
	} pulses_t;

	// one register bus request
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

endpackage : bcast_pkg

// >>> dv/cmp_units.sv
// compare unit side: counts pulse cycles
// assumes pulses registered on clk
module cmp_units
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// fan-out pulses
	input  wire bcast_pkg::pulses_t pulses,
	output int                      seen
);
	timeunit 1ns;
	timeprecision 1ps;
	// count cycles with any pulse
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			seen <= 0;
		else if (pulses != 5'h00)
			seen <= seen + 1;
endmodule : cmp_units

// >>> dv/bcast_fanout_tb.sv
// bench: random writes, reads and step commands
// assumes register at 0, pulses one cycle after a command
module bcast_fanout_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, sequencer_enable = 0, sequencer_start = 0, step_exec = 0, step_is_ctrl = 0;
	logic [3:0]          step_option = 4'h0, ad;
	logic [15:0]         rdata, wd;
	logic [4:0]          exp_r = 5'h00;
	logic [1:0]          lk;
	bcast_pkg::bus_req_t bus = '0;
	bcast_pkg::pulses_t  pulses;
	int seed = 32'hc62d, err_total = 0, samples_checked = 0, nb = 0, seen;
	bcast_fanout u_bcast_fanout (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
		.sequencer_enable(sequencer_enable), .sequencer_start(sequencer_start), .step_exec(step_exec),
		.step_is_ctrl(step_is_ctrl), .step_option(step_option), .pulses(pulses));
	cmp_units u_cmp_units (.clk(clk), .rstn(rstn), .pulses(pulses), .seen(seen));
	// clock
	initial forever #20 clk = ~clk;
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		err_total += (s !== e);
		if (s !== e)
			$display("Error %s expected %h seen %h", n, e, s);
	endtask : check
	// expected read data: only bits 4:0 stored, other addresses read zero
	function automatic logic [15:0] exp_rdata(input logic [3:0] a, input logic [4:0] r);
		return (a == 4'h0) ? {11'h000, r} : 16'h0000;
	endfunction : exp_rdata
	// expected pulse word: register bits only for the broadcast control command
	function automatic logic [15:0] exp_pulses(input logic c, input logic [3:0] o, input logic [4:0] r);
		return (c && o == 4'hF) ? {11'h000, r} : 16'h0000;
	endfunction : exp_pulses
	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// watchdog
	initial
	begin
		#100000;
		err_total++;
		summarize();
	end
	// write, read back, step, check pulses
	initial
	begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		// corner: reset value, all bits set, two broadcasts back to back, locked write
		@(posedge clk);
		bus <= '{4'h0, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '{4'h0, 16'hFFFF, 1'b1, 1'b0};
		#1 check("rdata_reset", rdata, 16'h0000);
		@(posedge clk);
		bus <= '0;
		step_exec <= 1'b1;
		step_is_ctrl <= 1'b1;
		step_option <= 4'hF;
		@(posedge clk);
		sequencer_enable <= 1'b1;
		sequencer_start <= 1'b1;
		bus <= '{4'h0, 16'h0000, 1'b1, 1'b0};
		#1 check("pulses_first", 16'(pulses), exp_pulses(1'b1, 4'hF, 5'h1F));
		@(posedge clk);
		step_exec <= 1'b0;
		bus <= '{4'h0, 16'h0000, 1'b0, 1'b1};
		#1 check("pulses_second", 16'(pulses), exp_pulses(1'b1, 4'hF, 5'h1F));
		@(posedge clk);
		bus <= '0;
		sequencer_enable <= 1'b0;
		sequencer_start <= 1'b0;
		#1 check("pulses_gap", 16'(pulses), 16'h0000);
		check("rdata_locked", rdata, exp_rdata(4'h0, 5'h1F));
		exp_r = 5'h1F;
		nb = 2;
		repeat (200)
		begin
			@(posedge clk);
			lk = 2'($random(seed));
			wd = 16'($random(seed));
			ad = ($random(seed) & 1) ? 4'h0 : 4'($random(seed));
			sequencer_enable <= lk[0];
			sequencer_start <= lk[1];
			bus <= '{ad, wd, 1'b1, 1'b0};
			@(posedge clk);
			bus <= '{ad, 16'h0000, 1'b0, 1'b1};
			if (ad == 4'h0 && lk != 2'b11)
				exp_r = wd[4:0];
			@(posedge clk);
			bus <= '0;
			step_exec <= 1'b1;
			step_is_ctrl <= 1'($random(seed));
			step_option <= ($random(seed) & 1) ? 4'hF : 4'($random(seed));
			#1 check("rdata", rdata, exp_rdata(ad, exp_r));
			@(posedge clk);
			step_exec <= 1'b0;
			#1 check("pulses", 16'(pulses), exp_pulses(step_is_ctrl, step_option, exp_r));
			check("rdata_end", rdata, 16'h0000);
			nb += (exp_pulses(step_is_ctrl, step_option, exp_r) != 16'h0000);
			@(posedge clk);
			#1 check("pulse_end", 16'(pulses), 16'h0000);
		end
		check("pulse_count", 16'(seen), 16'(nb));
		summarize();
	end
endmodule : bcast_fanout_tb
